/* File: mtr_checker_properties.sv */
// port assertions for the thermal replica block
`timescale 1ns/1ps
module mtr_checker
  import mtr_pkg::*;
#(
  parameter int unsigned STEP_CLKS = STEP_CYCLES
) (
  input wire logic               clk_sys,
  input wire logic               reset_n,
  input wire logic [15:0]        phase_a_current,
  input wire logic [15:0]        phase_b_current,
  input wire logic [15:0]        phase_c_current,
  input wire logic               ambient_from_rtd,
  input wire logic signed [15:0] manual_temperature,
  input wire logic               settings_in_fahrenheit,
  input wire logic signed [15:0] low_temperature,
  input wire logic signed [15:0] high_temperature,
  input wire logic signed [15:0] reference_temperature,
  input wire logic [15:0]        low_temp_factor,
  input wire logic [15:0]        high_temp_factor,
  input wire logic               use_curve,
  input wire logic [31:0]        thermal_status_reg,
  input wire logic [31:0]        ambient_correction_coeff_reg,
  input wire logic [15:0]        largest_phase_current_reg,
  input wire logic               long_heating_reg,
  input wire logic               status_valid_reg
);
  // ==========================================================================
  // helpers
  logic [31:0] gap_reg;
  logic        seen_reg;
  logic [15:0] top_phase;
  logic        lin_done;

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      {gap_reg, seen_reg} <= '0;
    else
    begin
      gap_reg  <= status_valid_reg ? 32'h1 : gap_reg + 32'h1;
      seen_reg <= seen_reg | status_valid_reg;
    end
  end

  always_comb
  begin
    top_phase = phase_a_current;
    if (phase_b_current > top_phase) top_phase = phase_b_current;
    if (phase_c_current > top_phase) top_phase = phase_c_current;
  end

  // linear law, manual ambient in degrees C, at the end of a step
  assign lin_done = status_valid_reg && !use_curve && !ambient_from_rtd && !settings_in_fahrenheit;

  // ==========================================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_pulse; status_valid_reg |=> !status_valid_reg; endproperty
  a_pulse: assert property (p_pulse) else $error("valid pulse too long");
  property p_first;
    status_valid_reg && !seen_reg |-> gap_reg >= STEP_CLKS && gap_reg <= STEP_CLKS + 300;
  endproperty
  a_first: assert property (p_first) else $error("first step out of window");
  property p_period; status_valid_reg && seen_reg |-> gap_reg == STEP_CLKS; endproperty
  a_period: assert property (p_period) else $error("step period wrong");
  property p_reset;
    disable iff (1'b0) !reset_n |=> ambient_correction_coeff_reg == UNITY_Q16
      && thermal_status_reg == 32'h0 && !status_valid_reg;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  property p_hold; $changed(thermal_status_reg) |-> status_valid_reg; endproperty
  a_hold: assert property (p_hold) else $error("status moved off step");
  property p_heat; $changed(long_heating_reg) |-> ##[0:300] status_valid_reg; endproperty
  a_heat: assert property (p_heat) else $error("heating flag off step");
  property p_largest;
    $changed(largest_phase_current_reg) |-> largest_phase_current_reg == top_phase;
  endproperty
  a_largest: assert property (p_largest) else $error("largest phase wrong");
  property p_low;
    lin_done && manual_temperature <= low_temperature
      |-> ambient_correction_coeff_reg == {8'h00, low_temp_factor, 8'h00};
  endproperty
  a_low: assert property (p_low) else $error("low clamp wrong");
  property p_high;
    lin_done && manual_temperature >= high_temperature
      |-> ambient_correction_coeff_reg == {8'h00, high_temp_factor, 8'h00};
  endproperty
  a_high: assert property (p_high) else $error("high clamp wrong");
  property p_ref;
    lin_done && manual_temperature == reference_temperature
      |-> ambient_correction_coeff_reg == UNITY_Q16;
  endproperty
  a_ref: assert property (p_ref) else $error("reference factor wrong");

  c_step: cover property (status_valid_reg);
  c_heat: cover property ($rose(long_heating_reg));
  c_curve: cover property (status_valid_reg && use_curve);
  c_fahr: cover property (status_valid_reg && settings_in_fahrenheit);
endmodule : mtr_checker

bind mtr_thermal_replica mtr_checker #(.STEP_CLKS(STEP_CLKS)) u_checker (
  .clk_sys, .reset_n, .phase_a_current, .phase_b_current, .phase_c_current,
  .ambient_from_rtd, .manual_temperature, .settings_in_fahrenheit,
  .low_temperature, .high_temperature, .reference_temperature,
  .low_temp_factor, .high_temp_factor, .use_curve, .thermal_status_reg,
  .ambient_correction_coeff_reg, .largest_phase_current_reg,
  .long_heating_reg, .status_valid_reg);

/* File: mtr_divider.sv */
// sequential unsigned restoring divider, one quotient bit per cycle
`timescale 1ns/1ps
module mtr_divider #(
  parameter int unsigned W = 48
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output logic              done,
  output logic [W-1:0]      quotient
);
  import mtr_pkg::*;

  if (W < 8) $error("divider width too small");

  logic [W:0]           rem_reg;
  logic [W-1:0]         den_reg;
  logic [$clog2(W):0]   cnt_reg;
  logic                 busy_reg;
  logic [W:0]           rem_shift;

  assign rem_shift = {rem_reg[W-1:0], quotient[W-1]};

  // ==========================================================================
  // shift and subtract
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      rem_reg  <= '0;
      den_reg  <= '0;
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done     <= 1'b0;
      quotient <= '0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      if (start)
      begin
        rem_reg  <= '0;
        den_reg  <= divisor;
        quotient <= dividend;
        cnt_reg  <= '0;
        busy_reg <= 1'b1;
      end
      else if (busy_reg)
      begin
        if (rem_shift >= {1'b0, den_reg})
        begin
          rem_reg  <= rem_shift - {1'b0, den_reg};
          quotient <= {quotient[W-2:0], 1'b1};
        end
        else
        begin
          rem_reg  <= rem_shift;
          quotient <= {quotient[W-2:0], 1'b0};
        end
        cnt_reg <= cnt_reg + 1'b1;
        if (cnt_reg == ($clog2(W)+1)'(W - 1))
        begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
        end
      end
    end
  end

endmodule : mtr_divider

/* File: mtr_meas_model.sv */
// measurement chain model: rms currents, sequence currents, rtd and run state
`timescale 1ns/1ps
module mtr_meas_model (
  input  wire logic               clk_sys,
  input  wire logic [15:0]        set_a,
  input  wire logic [15:0]        set_b,
  input  wire logic [15:0]        set_c,
  input  wire logic [15:0]        set_pos,
  input  wire logic [15:0]        set_neg,
  input  wire logic signed [15:0] set_rtd,
  input  wire logic               set_run,
  output logic [15:0]             phase_a_current,
  output logic [15:0]             phase_b_current,
  output logic [15:0]             phase_c_current,
  output logic [15:0]             pos_seq_current,
  output logic [15:0]             neg_seq_current,
  output logic signed [15:0]      rtd_temperature,
  output logic                    machine_running
);
  // ==========================================================================
  // refreshed every cycle
  always_ff @(posedge clk_sys)
  begin
    phase_a_current <= set_a;
    phase_b_current <= set_b;
    phase_c_current <= set_c;
    pos_seq_current <= set_pos;
    neg_seq_current <= set_neg;
    rtd_temperature <= set_rtd;
    machine_running <= set_run;
  end
endmodule : mtr_meas_model

/* File: mtr_pkg.sv */
// constants and types shared by the thermal replica block
package mtr_pkg;

  // ==========================================================================
  // timebase
  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned STEP_MS       = 5;
  localparam int unsigned STEP_CYCLES   = STEP_MS * 1000 * CLK_MHZ;
  localparam int unsigned MS_PER_MIN    = 60000;
  localparam int unsigned STEPS_PER_MIN = MS_PER_MIN / STEP_MS;

  // ==========================================================================
  // number formats and fixed values
  localparam int unsigned DIV_W      = 48;
  localparam int unsigned IMG_W      = 48;
  localparam int unsigned MAX_POINTS = 10;
  localparam int unsigned MIN_POINTS = 2;
  localparam logic [31:0] UNITY_Q16  = 32'h0001_0000;
  localparam logic [15:0] UNITY_Q8   = 16'h0100;
  localparam logic [16:0] WF_ONE     = 17'h1_0000;
  localparam logic [7:0]  PCT_SCALE  = 8'h64;
  localparam logic signed [15:0] REF_TEMP_DEFAULT = 16'sh0190;
  localparam logic signed [31:0] F_OFFSET = 32'sh0000_0140;

  // ==========================================================================
  // calculation sequence
  typedef enum logic [2:0] {
    MTR_IDLE,
    MTR_AMB,
    MTR_RATIO,
    MTR_NORM,
    MTR_LONG,
    MTR_SHORT,
    MTR_OUT
  } mtr_state_t;

endpackage : mtr_pkg

/* File: mtr_thermal_replica.sv */
// two time-constant thermal replica of an electric machine
`timescale 1ns/1ps
module mtr_thermal_replica #(
  parameter int unsigned STEP_CLKS = mtr_pkg::STEP_CYCLES,
  parameter int unsigned NPTS      = mtr_pkg::MAX_POINTS
) (
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  input  wire logic                    clk_en,
  input  wire logic [15:0]             phase_a_current,
  input  wire logic [15:0]             phase_b_current,
  input  wire logic [15:0]             phase_c_current,
  input  wire logic [15:0]             pos_seq_current,
  input  wire logic [15:0]             neg_seq_current,
  input  wire logic [15:0]             full_capacity_current,
  input  wire logic [15:0]             service_factor_coeff,
  input  wire logic [15:0]             unbalance_bias_weight,
  input  wire logic [15:0]             image_split_weight,
  input  wire logic [15:0]             long_heat_constant,
  input  wire logic [15:0]             long_cool_stopped_constant,
  input  wire logic [15:0]             long_cool_running_constant,
  input  wire logic [15:0]             short_heat_constant,
  input  wire logic [15:0]             short_cool_constant,
  input  wire logic                    machine_running,
  input  wire logic                    ambient_from_rtd,
  input  wire logic signed [15:0]      rtd_temperature,
  input  wire logic signed [15:0]      manual_temperature,
  input  wire logic                    settings_in_fahrenheit,
  input  wire logic signed [15:0]      low_temperature,
  input  wire logic signed [15:0]      high_temperature,
  input  wire logic signed [15:0]      reference_temperature,
  input  wire logic [15:0]             low_temp_factor,
  input  wire logic [15:0]             high_temp_factor,
  input  wire logic                    use_curve,
  input  wire logic [3:0]              curve_points,
  input  wire logic [NPTS-1:0][15:0]   curve_temperature,
  input  wire logic [NPTS-1:0][15:0]   curve_factor,
  output logic [31:0]                  thermal_status_reg,
  output logic [31:0]                  ambient_correction_coeff_reg,
  output logic [15:0]                  largest_phase_current_reg,
  output logic                         long_heating_reg,
  output logic                         status_valid_reg
);
  import mtr_pkg::*;

  if (STEP_CLKS < 512) $error("step period too short for one calculation");
  if (NPTS < MIN_POINTS || NPTS > 15) $error("curve point count out of range");

  // ==========================================================================
  // helpers
  function automatic logic signed [15:0] to_celsius(input logic signed [15:0] t,
                                                    input logic fahr);
    logic signed [31:0] w;
    w = ((32'(t) - F_OFFSET) * 32'sd5) / 32'sd9;
    to_celsius = fahr ? w[15:0] : t;
  endfunction : to_celsius

  function automatic logic [DIV_W-1:0] absdiff(input logic [IMG_W-1:0] a,
                                               input logic [IMG_W-1:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction : absdiff

  function automatic logic [DIV_W-1:0] tau_den(input logic [15:0] tau);
    tau_den = DIV_W'(32'((tau == 16'h0) ? 16'h1 : tau) * STEPS_PER_MIN);
  endfunction : tau_den

  // ==========================================================================
  // step timebase
  logic [31:0] tick_cnt_reg;
  logic        tick;

  assign tick = (tick_cnt_reg == STEP_CLKS - 1);

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      tick_cnt_reg <= '0;
    else if (clk_en)
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'h1;
  end

  // ==========================================================================
  // ambient factor: segment choice over linear law or settable curve
  logic signed [15:0] amb_temp;
  logic signed [15:0] pt_t [NPTS];
  logic [15:0]        pt_k [NPTS];
  logic [3:0]         pt_n;
  logic [3:0]         seg;
  logic               clamp;
  logic [15:0]        clamp_k;

  always_comb
  begin
    amb_temp = ambient_from_rtd ? rtd_temperature
             : to_celsius(manual_temperature, settings_in_fahrenheit);
    for (int i = 0; i < NPTS; i++)
    begin
      pt_t[i] = to_celsius(curve_temperature[i], settings_in_fahrenheit);
      pt_k[i] = curve_factor[i];
    end
    pt_n = (curve_points < 4'(MIN_POINTS)) ? 4'(MIN_POINTS)
         : (curve_points > 4'(NPTS)) ? 4'(NPTS) : curve_points;
    if (!use_curve)
    begin
      pt_t[0] = to_celsius(low_temperature, settings_in_fahrenheit);
      pt_t[1] = to_celsius(reference_temperature, settings_in_fahrenheit);
      pt_t[2] = to_celsius(high_temperature, settings_in_fahrenheit);
      pt_k[0] = low_temp_factor;
      pt_k[1] = UNITY_Q8;
      pt_k[2] = high_temp_factor;
      pt_n    = 4'd3;
    end
    seg = '0;
    for (int i = 1; i < NPTS - 1; i++)
      if (4'(i) < pt_n - 4'd1 && amb_temp >= pt_t[i])
        seg = 4'(i);
    clamp   = 1'b0;
    clamp_k = pt_k[0];
    if (amb_temp <= pt_t[0])
      clamp = 1'b1;
    else if (amb_temp >= pt_t[pt_n - 4'd1])
    begin
      clamp   = 1'b1;
      clamp_k = pt_k[pt_n - 4'd1];
    end
  end

  logic [15:0] seg_k0;
  logic [15:0] seg_k1;
  logic [15:0] seg_dt;
  logic [15:0] amb_dt;
  logic [15:0] seg_dk;

  assign seg_k0 = pt_k[seg];
  assign seg_k1 = pt_k[seg + 4'd1];
  assign seg_dt = 16'(pt_t[seg + 4'd1] - pt_t[seg]);
  assign amb_dt = 16'(amb_temp - pt_t[seg]);
  assign seg_dk = (seg_k1 >= seg_k0) ? seg_k1 - seg_k0 : seg_k0 - seg_k1;

  // ==========================================================================
  // shared divider
  logic              div_go_reg;
  logic [DIV_W-1:0]  div_num_reg;
  logic [DIV_W-1:0]  div_den_reg;
  logic              div_done;
  logic [DIV_W-1:0]  div_q;

  mtr_divider #(.W(DIV_W)) u_div (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .start    (div_go_reg),
    .dividend (div_num_reg),
    .divisor  (div_den_reg),
    .done     (div_done),
    .quotient (div_q)
  );

  // ==========================================================================
  // datapath terms
  mtr_state_t        state_reg;
  logic [15:0]       largest_phase_current;
  logic              amb_up_reg;
  logic [31:0]       factor_reg;
  logic [IMG_W-1:0]  target_reg;
  logic [IMG_W-1:0]  long_img_reg;
  logic [IMG_W-1:0]  short_img_reg;
  logic [31:0]       ratio_sq;
  logic [31:0]       base_q16;
  logic [63:0]       norm_sq;
  logic [IMG_W-1:0]  target;
  logic              long_heat;
  logic              short_heat;
  logic [15:0]       short_tau;
  logic [63:0]       weighted;

  always_comb
  begin
    largest_phase_current = phase_a_current;
    if (phase_b_current > largest_phase_current)
      largest_phase_current = phase_b_current;
    if (phase_c_current > largest_phase_current)
      largest_phase_current = phase_c_current;
  end

  assign ratio_sq   = 32'((64'(div_q[31:0]) * 64'(div_q[31:0])) >> 16);
  assign base_q16   = 32'((64'(32'(full_capacity_current) * 32'(service_factor_coeff))
                    * 64'(ambient_correction_coeff_reg)) >> 16);
  assign norm_sq    = 64'(div_q[31:0]) * 64'(div_q[31:0]);
  assign target     = IMG_W'((96'(norm_sq) * 96'(factor_reg)) >> 16);
  assign long_heat  = target_reg > long_img_reg;
  assign short_heat = target_reg > short_img_reg;
  assign short_tau  = short_heat ? short_heat_constant : short_cool_constant;
  assign weighted   = 64'((96'(long_img_reg) * 96'(WF_ONE - 17'(image_split_weight))
                    + 96'(short_img_reg) * 96'(image_split_weight)) >> 16);

  // ==========================================================================
  // calculation sequence
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_reg                    <= MTR_IDLE;
      div_go_reg                   <= 1'b0;
      div_num_reg                  <= '0;
      div_den_reg                  <= '0;
      amb_up_reg                   <= 1'b0;
      factor_reg                   <= UNITY_Q16;
      target_reg                   <= '0;
      long_img_reg                 <= '0;
      short_img_reg                <= '0;
      thermal_status_reg           <= '0;
      ambient_correction_coeff_reg <= UNITY_Q16;
      largest_phase_current_reg    <= '0;
      long_heating_reg             <= 1'b0;
      status_valid_reg             <= 1'b0;
    end
    else if (clk_en)
    begin
      div_go_reg       <= 1'b0;
      status_valid_reg <= 1'b0;
      case (state_reg)
        MTR_IDLE:
        begin
          if (tick)
          begin
            largest_phase_current_reg <= largest_phase_current;
            amb_up_reg  <= seg_k1 >= seg_k0;
            div_num_reg <= DIV_W'({32'(seg_dk) * 32'(amb_dt), 8'h00});
            div_den_reg <= DIV_W'((seg_dt == 16'h0) ? 16'h1 : seg_dt);
            div_go_reg  <= 1'b1;
            state_reg   <= MTR_AMB;
          end
        end
        MTR_AMB:
        begin
          if (div_done)
          begin
            if (clamp || seg_dt == 16'h0)
              ambient_correction_coeff_reg <= {8'h00, clamp_k, 8'h00};
            else if (amb_up_reg)
              ambient_correction_coeff_reg <= {8'h00, seg_k0, 8'h00} + div_q[31:0];
            else
              ambient_correction_coeff_reg <= {8'h00, seg_k0, 8'h00} - div_q[31:0];
            div_num_reg <= DIV_W'({neg_seq_current, 16'h0000});
            div_den_reg <= DIV_W'((pos_seq_current == 16'h0) ? 16'h1 : pos_seq_current);
            div_go_reg  <= 1'b1;
            state_reg   <= MTR_RATIO;
          end
        end
        MTR_RATIO:
        begin
          if (div_done)
          begin
            factor_reg <= (pos_seq_current == 16'h0) ? UNITY_Q16
                        : UNITY_Q16
                        + 32'((64'(ratio_sq) * 64'(unbalance_bias_weight)) >> 8);
            div_num_reg <= DIV_W'({largest_phase_current_reg, 24'h00_0000});
            div_den_reg <= DIV_W'((base_q16 == 32'h0) ? 32'h1 : base_q16);
            div_go_reg  <= 1'b1;
            state_reg   <= MTR_NORM;
          end
        end
        MTR_NORM:
        begin
          if (div_done)
          begin
            target_reg <= target;
            state_reg  <= MTR_LONG;
            div_go_reg <= 1'b1;
            div_num_reg <= absdiff(target, long_img_reg);
            // constant chosen here so every step takes the same number of cycles
            div_den_reg <= tau_den((target > long_img_reg) ? long_heat_constant
                                   : machine_running ? long_cool_running_constant
                                   : long_cool_stopped_constant);
          end
        end
        MTR_LONG:
        begin
          if (div_done)
          begin
            long_img_reg     <= long_heat ? long_img_reg + div_q
                                          : long_img_reg - div_q;
            long_heating_reg <= long_heat;
            div_num_reg <= absdiff(target_reg, short_img_reg);
            div_den_reg <= tau_den(short_tau);
            div_go_reg  <= 1'b1;
            state_reg   <= MTR_SHORT;
          end
        end
        MTR_SHORT:
        begin
          if (div_done)
          begin
            short_img_reg <= short_heat ? short_img_reg + div_q : short_img_reg - div_q;
            state_reg     <= MTR_OUT;
          end
        end
        MTR_OUT:
        begin
          thermal_status_reg <= 32'((96'(weighted) * 96'(PCT_SCALE)) >> 16);
          status_valid_reg   <= 1'b1;
          state_reg          <= MTR_IDLE;
        end
        default:
          state_reg <= MTR_IDLE;
      endcase
    end
  end

endmodule : mtr_thermal_replica

/* File: mtr_thermal_replica_tb.sv */
// self-checking bench for the thermal replica block
`timescale 1ns/1ps
module mtr_thermal_replica_tb;
  import mtr_pkg::*;
  localparam int unsigned STEP = 600;
  localparam int unsigned LIMIT = 60000;

  logic clk_sys, reset_n;
  logic clk_en = 1'b1;
  logic [15:0] set_a, set_b, set_c, set_pos, set_neg;
  logic signed [15:0] set_rtd;
  logic set_run, ambient_from_rtd, settings_in_fahrenheit, use_curve;
  logic [15:0] full_capacity_current, service_factor_coeff, unbalance_bias_weight;
  logic [15:0] image_split_weight, long_heat_constant, long_cool_stopped_constant;
  logic [15:0] long_cool_running_constant, short_heat_constant, short_cool_constant;
  logic signed [15:0] manual_temperature, low_temperature, high_temperature;
  logic signed [15:0] reference_temperature;
  logic [15:0] low_temp_factor, high_temp_factor;
  logic [3:0] curve_points;
  logic [9:0][15:0] curve_temperature, curve_factor;
  logic [15:0] phase_a_current, phase_b_current, phase_c_current;
  logic [15:0] pos_seq_current, neg_seq_current, largest_phase_current_reg;
  logic signed [15:0] rtd_temperature;
  logic machine_running, long_heating_reg, status_valid_reg;
  logic [31:0] thermal_status_reg, ambient_correction_coeff_reg;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  mtr_meas_model u_meas (.clk_sys, .set_a, .set_b, .set_c, .set_pos, .set_neg, .set_rtd,
    .set_run, .phase_a_current, .phase_b_current, .phase_c_current, .pos_seq_current,
    .neg_seq_current, .rtd_temperature, .machine_running);

  mtr_thermal_replica #(.STEP_CLKS(STEP), .NPTS(10)) dut (.clk_sys, .reset_n, .clk_en,
    .phase_a_current, .phase_b_current, .phase_c_current, .pos_seq_current,
    .neg_seq_current, .full_capacity_current, .service_factor_coeff,
    .unbalance_bias_weight, .image_split_weight, .long_heat_constant,
    .long_cool_stopped_constant, .long_cool_running_constant, .short_heat_constant,
    .short_cool_constant, .machine_running, .ambient_from_rtd, .rtd_temperature,
    .manual_temperature, .settings_in_fahrenheit, .low_temperature, .high_temperature,
    .reference_temperature, .low_temp_factor, .high_temp_factor, .use_curve,
    .curve_points, .curve_temperature, .curve_factor, .thermal_status_reg,
    .ambient_correction_coeff_reg, .largest_phase_current_reg, .long_heating_reg,
    .status_valid_reg);

  // ==========================================================================
  // common tasks
  task automatic wrap_up();
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      mismatches++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic near(input logic [31:0] seen, input logic [31:0] want);
    chk((seen + 32'h100 >= want && seen <= want + 32'h100) ? want : seen, want);
  endtask : near

  task automatic wait_valid();
    do @(negedge clk_sys); while (status_valid_reg !== 1'b1);
  endtask : wait_valid

  task automatic rst();
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask : rst

  task automatic defaults();
    {set_a, set_b, set_c, set_neg} <= '0;
    set_pos <= 16'h0100;
    set_rtd <= 16'sd0;
    {set_run, ambient_from_rtd, settings_in_fahrenheit, use_curve} <= '0;
    {full_capacity_current, service_factor_coeff} <= {2{16'h0100}};
    {unbalance_bias_weight, image_split_weight} <= '0;
    {long_heat_constant, short_heat_constant, short_cool_constant} <= {3{16'd1}};
    {long_cool_stopped_constant, long_cool_running_constant} <= {2{16'd1}};
    manual_temperature <= 16'sd400;
    low_temperature <= 16'sd0;
    reference_temperature <= 16'sd400;
    high_temperature <= 16'sd800;
    low_temp_factor <= 16'h0080;
    high_temp_factor <= 16'h0180;
    curve_points <= 4'd2;
  endtask : defaults

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    @(negedge clk_sys);
    chk(ambient_correction_coeff_reg, 32'h0001_0000);
    chk(thermal_status_reg, 32'h0);
  endtask : t_reset

  task automatic t_largest();
    logic [15:0] v [3] = '{16'h0300, 16'h0100, 16'h0200};
    for (int i = 0; i < 3; i++)
    begin
      wait_valid();
      @(posedge clk_sys);
      set_a <= v[i];
      set_b <= v[(i + 1) % 3];
      set_c <= v[(i + 2) % 3];
      wait_valid();
      chk({16'h0, largest_phase_current_reg}, 32'h0000_0300);
    end
  endtask : t_largest

  task automatic amb(input logic [2:0] m, input logic [3:0] pts,
                     input logic signed [15:0] temp, input logic [31:0] want);
    wait_valid();
    @(posedge clk_sys);
    {settings_in_fahrenheit, ambient_from_rtd, use_curve} <= m;
    low_temperature <= m[2] ? 16'sd320 : 16'sd0;
    reference_temperature <= m[2] ? 16'sd1040 : 16'sd400;
    high_temperature <= m[2] ? 16'sd1760 : 16'sd800;
    manual_temperature <= m[1] ? ~temp : temp;
    set_rtd <= m[1] ? temp : ~temp;
    curve_points <= pts;
    wait_valid();
    chk(ambient_correction_coeff_reg, want);
  endtask : amb

  task automatic t_ambient();
    @(posedge clk_sys);
    for (int i = 0; i < 10; i++)
    begin
      curve_temperature[i] <= 16'(i * 100);
      curve_factor[i] <= 16'h0100 + 16'(i * 16);
    end
    amb(3'h0, 4'd2, -16'sd100, 32'h8000);
    amb(3'h0, 4'd2, 16'sd900, 32'h1_8000);
    amb(3'h0, 4'd2, 16'sd400, 32'h1_0000);
    amb(3'h0, 4'd2, 16'sd200, 32'hc000);
    amb(3'h0, 4'd2, 16'sd600, 32'h1_4000);
    amb(3'h4, 4'd2, 16'sd680, 32'hc000);
    amb(3'h6, 4'd2, 16'sd800, 32'h1_8000);
    amb(3'h1, 4'd2, 16'sd50, 32'h1_0800);
    amb(3'h1, 4'd10, 16'sd850, 32'h1_8800);
  endtask : t_ambient

  task automatic t_image(input logic [15:0] sf, bias, neg, wf, lh, input logic [31:0] want);
    @(posedge clk_sys);
    defaults();
    set_a <= 16'h1000;
    service_factor_coeff <= sf;
    unbalance_bias_weight <= bias;
    set_neg <= neg;
    image_split_weight <= wf;
    long_heat_constant <= lh;
    rst();
    wait_valid();
    near(thermal_status_reg, want);
    chk({31'h0, long_heating_reg}, 32'h1);
  endtask : t_image

  task automatic t_cool();
    logic [31:0] s1, s2;
    @(posedge clk_sys);
    defaults();
    set_a <= 16'h1000;
    long_cool_stopped_constant <= 16'hffff;
    rst();
    repeat (3) wait_valid();
    s1 = thermal_status_reg;
    @(posedge clk_sys);
    set_a <= 16'h0;
    set_run <= 1'b1;
    wait_valid();
    chk({31'h0, long_heating_reg}, 32'h0);
    chk({31'h0, thermal_status_reg < s1}, 32'h1);
    s2 = thermal_status_reg;
    @(posedge clk_sys);
    set_run <= 1'b0;
    wait_valid();
    chk({31'h0, s2 - thermal_status_reg < 32'h4}, 32'h1);
  endtask : t_cool

  // ==========================================================================
  // clock, timeout and main sequence
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      wrap_up();
    end
  end

  initial
  begin
    reset_n <= 1'b0;
    curve_temperature <= '0;
    curve_factor <= '0;
    defaults();
    rst();
    t_reset();
    t_largest();
    t_ambient();
    t_image(16'h0100, 16'h0, 16'h0, 16'h0, 16'd1, 32'h0002_2222);
    t_image(16'h0200, 16'h0, 16'h0, 16'h0, 16'd1, 32'h0000_8888);
    t_image(16'h0100, 16'h0100, 16'h0100, 16'h0, 16'd1, 32'h0004_4444);
    t_image(16'h0100, 16'h0, 16'h0, 16'h4000, 16'd2, 32'h0001_5555);
    t_image(16'h0100, 16'h0, 16'h0, 16'h0, 16'd2, 32'h0001_1111);
    t_cool();
    wrap_up();
  end
endmodule : mtr_thermal_replica_tb
